//--- hdl/pwr_mode_pkg.sv
/*
 * constants and types shared by the power mode clock selector.
 * assumes a single system clock domain; control bits arrive as levels.
 */
// Overview of operation
// - halt with cpu_halt_select at 0 enters sleep; every clock stops.
// - run mode clocks cpu and peripherals; 00 primary, 01 secondary, 1x internal.
// - halt with cpu_halt_select at 1 gates cpu clock, peripherals stay clocked.
// - three sources; primary oscillator type fixed by four-bit configuration field.
// - changing clock_source_select switches at once if the new source oscillates.
// - idle or sleep entered only on halt; halt select sampled at that moment.
// - halt select is control bit 7, source select is bits 1:0.
// - internal block is fast oscillator, its postscaler, and slow oscillator.
package pwr_mode_pkg;
    localparam int CTRL_W = 8;
    localparam int HALT_SEL_BIT = 7;
    localparam int SRC_SEL_LO = 0;
    localparam int SRC_SEL_HI = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int PRI_CFG_W = 4;
    localparam logic [1:0] SRC_PRIMARY = 2'h0;
    localparam logic [1:0] SRC_SECONDARY = 2'h1;
    localparam logic [1:0] SRC_INTERNAL = 2'h2;
    localparam logic [1:0] SRC_NONE = 2'h3;

    typedef enum logic [2:0] {
        primary_run_mode,
        secondary_run_mode,
        internal_run_mode,
        primary_idle_mode,
        secondary_idle_mode,
        internal_idle_mode,
        sleep_mode
    } pwr_mode_type;
endpackage

//--- hdl/src_sel_if.sv
/*
 * carries the decoded source choice between selector and switch logic.
 * assumes one clock; all signals are levels.
 */
`timescale 1ns/1ns
interface src_sel_if;
    logic [1:0] want_src;
    logic [1:0] cur_src;
    logic src_ok;
    modport ctrl (output want_src, input cur_src, input src_ok);
    modport sw (input want_src, output cur_src, output src_ok);
endinterface

//--- hdl/clk_src_switch.sv
/*
 * source switch: follows the requested source once it is oscillating.
 * assumes oscillator ready levels are already synchronised by the caller.
 */
`timescale 1ns/1ns
module clk_src_switch
    import pwr_mode_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [2:0] osc_ready_i,
    src_sel_if.sw sel
);
    logic [1:0] cur_r;
    logic [1:0] cur_nxt;
    wire logic req_ready;

    // a source not yet oscillating keeps the old one; never glitch to dead
    assign req_ready = osc_ready_i[sel.want_src];
    assign cur_nxt = req_ready ? sel.want_src : cur_r;
    assign sel.cur_src = cur_r;
    assign sel.src_ok = req_ready;

    // current source register
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cur_r <= SRC_PRIMARY;
        else
            cur_r <= cur_nxt;
    end
endmodule

//--- hdl/power_mode_clock_selector.sv
/*
 * power mode selector: decides cpu and peripheral clock gating and source.
 * assumes halt_exec_i is a one-cycle pulse from the core on this clock,
 * wake_i is a same-domain level or pulse, and oscillator ready pins are
 * asynchronous and synchronised here.
 */
`timescale 1ns/1ns
module power_mode_clock_selector
    import pwr_mode_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ctrl_wr_i,
    input wire logic [pwr_mode_pkg::CTRL_W-1:0] ctrl_wdata_i,
    input wire logic [pwr_mode_pkg::PRI_CFG_W-1:0] primary_osc_config_i,
    input wire logic halt_exec_i,
    input wire logic wake_i,
    input wire logic [2:0] osc_ready_i,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic [1:0] clk_src_o,
    output logic [2:0] mode_o,
    output logic [pwr_mode_pkg::CTRL_W-1:0] ctrl_rdata_o,
    output logic [pwr_mode_pkg::PRI_CFG_W-1:0] primary_type_o
);
    import pwr_mode_pkg::*;

    // maps a source select onto one of exactly three sources; the
    // internal block counts as one source, oscillators and postscaler
    function automatic logic [1:0] src_decode(input logic [1:0] s);
        src_decode = s[1] ? SRC_INTERNAL : s;
    endfunction

    // true for the three modes in which the cpu is clocked
    function automatic logic mode_is_run(input pwr_mode_type m);
        mode_is_run = (m == primary_run_mode) ||
            (m == secondary_run_mode) || (m == internal_run_mode);
    endfunction

    // run or idle flavour of a source select; enums kept out of
    // ternaries so that no tool has to cast back to the mode type
    function automatic pwr_mode_type mode_for(input logic [1:0] s,
        input logic idle);
        pwr_mode_type m;
        case (src_decode(s))
            SRC_PRIMARY:
                if (idle)
                    m = primary_idle_mode;
                else
                    m = primary_run_mode;
            SRC_SECONDARY:
                if (idle)
                    m = secondary_idle_mode;
                else
                    m = secondary_run_mode;
            default:
                if (idle)
                    m = internal_idle_mode;
                else
                    m = internal_run_mode;
        endcase
        mode_for = m;
    endfunction

    logic [7:0] oscillator_control_reg;
    logic [2:0] rdy_meta_r;
    logic [2:0] rdy_sync_r;
    pwr_mode_type mode_r;
    pwr_mode_type mode_nxt;
    logic cpu_en_r;
    logic per_en_r;
    logic [1:0] src_r;
    logic [2:0] mode_out_r;
    logic [3:0] pri_cfg_r;
    logic cfg_taken_r;
    logic [3:0] cfg_meta_r;
    logic [3:0] cfg_sync_r;
    logic [1:0] cfg_vld_r;
    wire logic cpu_halt_select;
    wire logic [1:0] clock_source_select;
    wire logic in_low_power;
    wire logic [1:0] sel_src;
    wire pwr_mode_type run_mode;
    wire pwr_mode_type idle_mode;
    wire logic cpu_en_nxt;
    wire logic per_en_nxt;
    wire logic [1:0] src_nxt;

    src_sel_if sel_bus ();

    clk_src_switch u_switch (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .osc_ready_i(rdy_sync_r),
        .sel(sel_bus.sw)
    );

    // field positions of the control word
    assign cpu_halt_select = oscillator_control_reg[HALT_SEL_BIT];
    assign clock_source_select =
        oscillator_control_reg[SRC_SEL_HI:SRC_SEL_LO];
    assign sel_bus.want_src = src_decode(clock_source_select);
    assign sel_src = sel_bus.cur_src;

    // run and idle flavours follow the live source select
    assign run_mode = mode_for(clock_source_select, 1'b0);
    assign idle_mode = mode_for(clock_source_select, 1'b1);
    assign in_low_power = !mode_is_run(mode_r);

    // mode sequencing; halt select read only at the halt itself
    always_comb
    begin
        mode_nxt = mode_r;
        if (in_low_power)
        begin
            if (wake_i)
                mode_nxt = run_mode;
            else if (mode_r != sleep_mode)
                mode_nxt = idle_mode;
        end
        else if (halt_exec_i)
        begin
            if (cpu_halt_select)
                mode_nxt = idle_mode;
            else
                mode_nxt = sleep_mode;
        end
        else
            mode_nxt = run_mode;
    end

    // clock gating per mode
    assign cpu_en_nxt = mode_is_run(mode_nxt);
    assign per_en_nxt = (mode_nxt != sleep_mode);
    // sleep reports no source since nothing is clocked
    assign src_nxt = (mode_nxt == sleep_mode) ? SRC_NONE : sel_src;

    // control word, written by software; bits 6:2 kept as written
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oscillator_control_reg <= CTRL_RESET;
        else if (ctrl_wr_i)
            oscillator_control_reg <= ctrl_wdata_i;
    end

    // two-stage synchroniser for oscillator ready pins
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdy_meta_r <= 3'h0;
            rdy_sync_r <= 3'h0;
        end
        else
        begin
            rdy_meta_r <= osc_ready_i;
            rdy_sync_r <= rdy_meta_r;
        end
    end

    // config pins enter through two flops like any pin; the valid pipe
    // marks when the second flop holds a real sample, not its reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_meta_r <= 4'h0;
            cfg_sync_r <= 4'h0;
            cfg_vld_r <= 2'h0;
        end
        else
        begin
            cfg_meta_r <= primary_osc_config_i;
            cfg_sync_r <= cfg_meta_r;
            cfg_vld_r <= {cfg_vld_r[0], 1'b1};
        end
    end

    // primary type is nonvolatile config, caught once per reset; later
    // pin changes are ignored until the next reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pri_cfg_r <= 4'h0;
            cfg_taken_r <= 1'b0;
        end
        else if (cfg_vld_r[1] && !cfg_taken_r)
        begin
            pri_cfg_r <= cfg_sync_r;
            cfg_taken_r <= 1'b1;
        end
    end

    // mode state and registered outputs
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_r <= primary_run_mode;
            cpu_en_r <= 1'b1;
            per_en_r <= 1'b1;
            src_r <= SRC_PRIMARY;
            mode_out_r <= primary_run_mode;
        end
        else
        begin
            mode_r <= mode_nxt;
            cpu_en_r <= cpu_en_nxt;
            per_en_r <= per_en_nxt;
            src_r <= src_nxt;
            mode_out_r <= mode_nxt;
        end
    end

    // every output straight from its flop
    assign cpu_clk_en_o = cpu_en_r;
    assign periph_clk_en_o = per_en_r;
    assign clk_src_o = src_r;
    assign mode_o = mode_out_r;
    assign ctrl_rdata_o = oscillator_control_reg;
    assign primary_type_o = pri_cfg_r;
endmodule

//--- bench/pwr_mode_monitor.sv
/* checker on the selector ports.
   assumes bind onto the top module. */
`timescale 1ns/1ns
module pwr_mode_monitor
    import pwr_mode_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ctrl_wr_i,
    input wire logic [CTRL_W-1:0] ctrl_wdata_i,
    input wire logic halt_exec_i,
    input wire logic wake_i,
    input wire logic [2:0] osc_ready_i,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic [1:0] clk_src_o,
    input wire logic [2:0] mode_o,
    input wire logic [CTRL_W-1:0] ctrl_rdata_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // run decode, and select 1x folded onto internal
    wire run_w = mode_o < 3'h3;
    wire [1:0] want_w = ctrl_wdata_i[1] ? 2'h2 : ctrl_wdata_i[1:0];
    sleep_entry_a: assert property (run_w && halt_exec_i &&
        !ctrl_rdata_o[7] |=> mode_o == 3'h6 && !cpu_clk_en_o)
        else $error("no sleep");
    idle_entry_a: assert property (run_w && halt_exec_i &&
        ctrl_rdata_o[7] |=> !cpu_clk_en_o && periph_clk_en_o)
        else $error("no idle");
    run_clocks_a: assert property (run_w |->
        cpu_clk_en_o && periph_clk_en_o) else $error("run gated");
    sleep_off_a: assert property (mode_o == 3'h6 |->
        clk_src_o == 2'h3 && !periph_clk_en_o) else $error("sleep on");
    halt_only_a: assert property (run_w && !halt_exec_i |=> run_w)
        else $error("left run");
    wake_run_a: assert property (!run_w && wake_i |=>
        run_w && cpu_clk_en_o) else $error("no wake");
    ctrl_bits_a: assert property (ctrl_wr_i |=>
        ctrl_rdata_o == $past(ctrl_wdata_i)) else $error("ctrl");
    src_switch_a: assert property (run_w && ctrl_wr_i &&
        $past(osc_ready_i) == 3'h7 |->
        ##3 clk_src_o == $past(want_w, 3)) else $error("no switch");
endmodule
bind power_mode_clock_selector pwr_mode_monitor i_mon (.*);

//--- bench/core_model.sv
/* core that executes the halt instruction.
   assumes the selector's clock. */
`timescale 1ns/1ns
module core_model
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic cpu_clk_en_i,
    input wire logic halt_req_i,
    output logic halt_exec_o
);
    // a gated core runs nothing, so no halt from idle or sleep
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            halt_exec_o <= 1'b0;
        else
            halt_exec_o <= halt_req_i && cpu_clk_en_i;
    end
endmodule

//--- bench/power_mode_clock_selector_tb_top.sv
/* bench for the selector with a core model.
   assumes package, interface and design compiled first. */
`timescale 1ns/1ns
module power_mode_clock_selector_tb_top;
    logic clk = 0, rst_n = 0, wr = 0, hreq = 0, wake = 0, hx, cpu, per;
    logic [7:0] wd = 8'h00;
    logic [7:0] rd;
    logic [3:0] ty;
    logic [2:0] rdy = 3'h7;
    logic [3:0] cfg = 4'h9;
    logic [2:0] mode;
    logic [1:0] src;
    int error_cnt = 0;
    int num_checks = 0;
    // 100 MHz system clock
    initial forever #5 clk = ~clk;
    core_model i_core (.clk_sys_i(clk), .rst_n_i(rst_n),
        .cpu_clk_en_i(cpu), .halt_req_i(hreq), .halt_exec_o(hx));
    power_mode_clock_selector i_dut (.clk_sys_i(clk), .rst_n_i(rst_n),
        .ctrl_wr_i(wr), .ctrl_wdata_i(wd), .primary_osc_config_i(cfg),
        .halt_exec_i(hx), .wake_i(wake), .osc_ready_i(rdy),
        .cpu_clk_en_o(cpu), .periph_clk_en_o(per), .clk_src_o(src),
        .mode_o(mode), .ctrl_rdata_o(rd), .primary_type_o(ty));
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr_ctrl(logic [7:0] v);
        @(posedge clk) wr <= 1'b1;
        wd <= v;
        @(posedge clk) wr <= 1'b0;
    endtask
    // bounded: a stuck switch ends the run
    task automatic wait_src(logic [1:0] e);
        int i;
        #1;
        for (i = 0; i < 8 && src !== e; i++)
            @(posedge clk) #1;
        chk("src", {6'h0, src}, {6'h0, e});
        if (i == 8)
            stop_test();
    endtask
    // halt via the core, then wake back to the run mode r
    task automatic halt_wake(logic [2:0] m, logic p, logic [1:0] hs,
        logic [2:0] r);
        @(posedge clk) hreq <= 1'b1;
        @(posedge clk) hreq <= 1'b0;
        @(posedge clk) #1;
        chk("halt", {4'h0, mode, cpu}, {4'h0, m, 1'b0});
        chk("per", {7'h0, per}, {7'h0, p});
        chk("hsrc", {6'h0, src}, {6'h0, hs});
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        #1;
        chk("wake", {4'h0, mode, cpu}, {4'h0, r, 1'b1});
        chk("wper", {5'h0, per, src}, {5'h0, 1'b1, r[1:0]});
    endtask
    task automatic scen_idle(logic [1:0] s);
        logic [1:0] e;
        e = s[1] ? 2'h2 : s;
        wr_ctrl({1'b1, 5'h0, s});
        wait_src(e);
        chk("ctrl", rd, {1'b1, 5'h0, s});
        halt_wake(3'h3 + e, 1'b1, e, {1'b0, e});
    endtask
    // secondary not oscillating: switch held off until it is
    task automatic scen_held();
        wr_ctrl(8'h02);
        wait_src(2'h2);
        @(posedge clk) rdy <= 3'h5;
        repeat (3) @(posedge clk);
        wr_ctrl(8'h01);
        repeat (4) @(posedge clk);
        #1;
        chk("held", {6'h0, src}, 8'h02);
        @(posedge clk) rdy <= 3'h7;
        wait_src(2'h1);
    endtask
    // sleep by halt select 0; a second halt alone sleeps again
    task automatic scen_sleep();
        wr_ctrl(8'h01);
        halt_wake(3'h6, 1'b0, 2'h3, 3'h1);
        halt_wake(3'h6, 1'b0, 2'h3, 3'h1);
    endtask
    // reset state, config caught once, later pin changes ignored
    task automatic scen_reset(logic [3:0] c);
        repeat (3) @(posedge clk);
        #1;
        chk("type", {4'h0, ty}, {4'h0, c});
        chk("rst", {1'b0, src, mode, cpu, per}, 8'h03);
        chk("rd", rd, 8'h00);
        @(posedge clk) cfg <= ~c;
        repeat (4) @(posedge clk);
        #1;
        chk("type hold", {4'h0, ty}, {4'h0, c});
    endtask
    // select change while idle moves to the matching idle flavour
    task automatic scen_idle_move();
        wr_ctrl(8'h80);
        wait_src(2'h0);
        @(posedge clk) hreq <= 1'b1;
        @(posedge clk) hreq <= 1'b0;
        wr_ctrl(8'h81);
        repeat (2) @(posedge clk);
        #1;
        chk("imove", {3'h0, mode, cpu, per}, 8'h11);
        wait_src(2'h1);
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        #1;
        chk("iwake", {4'h0, mode, cpu}, 8'h03);
    endtask
    // reset in mid-run: state back to reset values, config caught anew
    task automatic scen_rerst();
        @(posedge clk) rst_n <= 1'b0;
        cfg <= 4'h6;
        @(posedge clk) #1;
        chk("rst mid", {1'b0, src, mode, cpu, per}, 8'h03);
        chk("rd mid", rd, 8'h00);
        @(posedge clk) rst_n <= 1'b1;
        scen_reset(4'h6);
        halt_wake(3'h6, 1'b0, 2'h3, 3'h0);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        scen_reset(4'h9);
        for (int s = 0; s < 4; s++)
            scen_idle(s[1:0]);
        scen_sleep();
        scen_held();
        scen_idle_move();
        scen_rerst();
        stop_test();
    end
endmodule
